// file: src/rx_ctl_regs.svh
// Purpose: Constants of the receiver control path: offsets, fields, counts.
// Assumes: pclk stands in for the crystal oscillator.
// Notes:   Included by its bare name; definitions only.
`ifndef RX_CTL_REGS_SVH
`define RX_CTL_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CTRL_OFS        12'h000
`define STATUS_OFS      12'h004
`define EDGE_OFS        12'h008

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_GAP_LSB    0
`define CTRL_GAP_MSB    7
`define CTRL_RESET      8'h01
`define ST_MODE_LSB     0
`define ST_RANGE_LSB    2
`define ST_DATA_BIT     4
`define ST_NEMPTY_BIT   5
`define ST_OVF_BIT      6
`define EDGE_VALID_BIT  31
`define DATA_IDLE       1'b1

// ----------------------------------------------------------------------
// Timing: divider factors and settle times in base ticks (rounded up)
// ----------------------------------------------------------------------
`define DIV_BAND0       4'd10
`define DIV_BAND1       4'd14
`define SETTLE_R0       10'd897
`define SETTLE_R1       10'd513
`define SETTLE_R2       10'd513
`define SETTLE_R3       10'd321
`define EXT_R0          4'd8
`define EXT_R1          4'd4
`define EXT_R2          4'd2
`define EXT_R3          4'd1
`define FIFO_DEPTH      8
`define REC_W           16

`endif

// file: src/rx_ctl_pkg.sv
// Purpose: Types shared by the receiver control path.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only; numbers live in the header.
package rx_ctl_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        st_sleep,
        st_settle,
        st_wait_fall,
        st_recv
    } mode_t;

    typedef logic [1:0]  rate_range_t;
    typedef logic [31:0] word_t;
    typedef logic [11:0] addr_t;

endpackage : rx_ctl_pkg

// file: src/rx_clock_enable_data_sync.sv
// Purpose: Tick generation, mode sequencing and data resampling of an
//          ASK receiver, with an APB window and an edge record FIFO.
// Assumes: pclk is the oscillator; all pins are synchronous to pclk.
// Notes:   Edge records queue in an 8-deep FIFO read over APB.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`include "rx_ctl_regs.svh"

// ----------------------------------------------------------------------
// Edge record FIFO
// ----------------------------------------------------------------------
module edge_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count
    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage written only on an accepted push
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers wrap naturally; depth is a power of two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : edge_fifo

// What this block does
// - One base tick drives all sequencing timing
// - Base tick period set by band divider
// - Divide by 10 or by 14
// - Rate pins decode; 11 maps to range 2
// - Extended tick is 8/4/2 base ticks; range 3's 1 is never selected
// - Enable low keeps device asleep, inputs ignored
// - Enable high starts range-dependent settling
// - Receive until enable falls, then sleep
// - Demod data reaches output only when receiving
// - Forwarding starts at a falling input edge
// - Input sampled on extended tick only
// - Output edge spacing whole extended ticks
// - Minimum output edge gap suppresses spikes
module rx_clock_enable_data_sync (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire rx_ctl_pkg::addr_t   paddr,
    input  wire rx_ctl_pkg::word_t   pwdata,
    output rx_ctl_pkg::word_t        prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                enable_pin,
    input  wire logic                band_select,
    input  wire logic                rate_sel_msb,
    input  wire logic                rate_sel_lsb,
    input  wire logic                demod_raw,
    output logic                     data_out
);
    import rx_ctl_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mode_t            mode_r;
    rate_range_t      rate_range;
    logic [3:0]       base_div_r;
    logic [3:0]       base_last;
    logic             base_tick_r;
    logic [3:0]       ext_cnt_r;
    logic [3:0]       ext_len;
    logic             ext_tick_r;
    logic [9:0]       settle_cnt_r;
    logic [9:0]       settle_len;
    logic             enable_d_r;
    logic             sample_r;
    logic             data_r;
    logic [7:0]       gap_r;
    logic [14:0]      gap_cnt_r;
    logic             pend_valid_r;
    logic [15:0]      pend_rec_r;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic [15:0]      fifo_out_data;
    logic             fifo_pop;
    logic             ovf_r;
    logic             edge_now;
    logic             fall_now;
    logic             apb_done;
    logic             apb_wr;
    logic             apb_rd;
    word_t            rd_val;
    logic             rd_err;

    assign data_out = data_r;

    // ------------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------------
    // Rate pins to range; the pins cannot select the fastest range
    assign rate_range = rate_sel_msb ? 2'd2 : {1'b0, rate_sel_lsb};

    // Divider end value and extended length per range
    always_comb begin
        base_last = band_select ? (`DIV_BAND1 - 4'd1)
                                : (`DIV_BAND0 - 4'd1);
        case (rate_range)
            2'd0:    ext_len = `EXT_R0;
            2'd1:    ext_len = `EXT_R1;
            2'd2:    ext_len = `EXT_R2;
            default: ext_len = `EXT_R3;
        endcase
        case (rate_range)
            2'd0:    settle_len = `SETTLE_R0;
            2'd1:    settle_len = `SETTLE_R1;
            2'd2:    settle_len = `SETTLE_R2;
            default: settle_len = `SETTLE_R3;
        endcase
    end

    // Base tick free-runs even in sleep, like the oscillator itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_div_r  <= 4'h0;
            base_tick_r <= 1'b0;
        end else if (base_div_r >= base_last) begin
            base_div_r  <= 4'h0;
            base_tick_r <= 1'b1;
        end else begin
            base_div_r  <= base_div_r + 4'h1;
            base_tick_r <= 1'b0;
        end
    end

    // Extended tick counts base ticks; a range change applies to the period in progress
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_cnt_r  <= 4'h0;
            ext_tick_r <= 1'b0;
        end else if (base_tick_r) begin
            if (ext_cnt_r >= ext_len - 4'd1) begin
                ext_cnt_r  <= 4'h0;
                ext_tick_r <= 1'b1;
            end else begin
                ext_cnt_r  <= ext_cnt_r + 4'h1;
                ext_tick_r <= 1'b0;
            end
        end else begin
            ext_tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------------
    // Settle count in base ticks, restarted by a rising enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt_r <= 10'h000;
            enable_d_r   <= 1'b0;
        end else begin
            enable_d_r <= enable_pin;
            if (!enable_pin || !enable_d_r) begin
                settle_cnt_r <= 10'h000;
            end else if (mode_r == st_settle && base_tick_r) begin
                settle_cnt_r <= settle_cnt_r + 10'h001;
            end
        end
    end

    // Enable low always wins and returns to sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= st_sleep;
        end else if (!enable_pin) begin
            mode_r <= st_sleep;
        end else begin
            case (mode_r)
                st_sleep: begin
                    mode_r <= st_settle;
                end
                st_settle: begin
                    if (settle_cnt_r >= settle_len) begin
                        mode_r <= st_wait_fall;
                    end
                end
                st_wait_fall: begin
                    if (fall_now) begin
                        mode_r <= st_recv;
                    end
                end
                default: mode_r <= st_recv;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Data resampling and edge spacing
    // ------------------------------------------------------------------
    // Sample only on the extended tick; between ticks only sleep moves it, back to idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_r <= `DATA_IDLE;
        end else if (mode_r == st_sleep) begin
            sample_r <= `DATA_IDLE;
        end else if (ext_tick_r) begin
            sample_r <= demod_raw;
        end
    end

    // A falling sample opens the stream; later edges need the gap
    assign fall_now = ext_tick_r && sample_r && !demod_raw;
    assign edge_now = ext_tick_r && (demod_raw != data_r)
                      && (gap_cnt_r >= {7'h00, gap_r});

    // Output idles until the first falling edge is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r    <= `DATA_IDLE;
            gap_cnt_r <= 15'h0000;
        end else if (mode_r == st_sleep || mode_r == st_settle) begin
            data_r    <= `DATA_IDLE;
            gap_cnt_r <= 15'h0000;
        end else if (mode_r == st_wait_fall) begin
            if (fall_now) begin
                data_r    <= 1'b0;
                gap_cnt_r <= 15'h0001;
            end
        end else if (edge_now) begin
            data_r    <= demod_raw;
            gap_cnt_r <= 15'h0001;
        end else if (ext_tick_r && gap_cnt_r != 15'h7fff) begin
            gap_cnt_r <= gap_cnt_r + 15'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Edge records: level and spacing in extended ticks
    // ------------------------------------------------------------------
    // One record is held while the FIFO is full; a second one overwrites it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_valid_r <= 1'b0;
            pend_rec_r   <= 16'h0000;
        end else if (mode_r == st_recv && edge_now) begin
            pend_valid_r <= 1'b1;
            pend_rec_r   <= {demod_raw, gap_cnt_r};
        end else if (pend_valid_r && fifo_in_ready) begin
            pend_valid_r <= 1'b0;
        end
    end

    edge_fifo #(
        .WIDTH     (`REC_W),
        .DEPTH     (`FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (pend_valid_r),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_rec_r),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // ------------------------------------------------------------------
    // APB slave: one wait state, all answers registered
    // ------------------------------------------------------------------
    assign apb_done = psel && penable && pready;
    assign apb_wr   = apb_done && pwrite;
    assign apb_rd   = apb_done && !pwrite;
    assign fifo_pop = apb_rd && (paddr == `EDGE_OFS) && fifo_out_valid;

    // Read mux and decode error for unmapped words
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr == `CTRL_OFS) begin
            rd_val[`CTRL_GAP_MSB:`CTRL_GAP_LSB] = gap_r;
        end else if (paddr == `STATUS_OFS) begin
            rd_val[`ST_MODE_LSB +: 2]  = mode_r;
            rd_val[`ST_RANGE_LSB +: 2] = rate_range;
            rd_val[`ST_DATA_BIT]       = data_r;
            rd_val[`ST_NEMPTY_BIT]     = fifo_out_valid;
            rd_val[`ST_OVF_BIT]        = ovf_r;
        end else if (paddr == `EDGE_OFS) begin
            rd_val[`EDGE_VALID_BIT]    = fifo_out_valid;
            rd_val[15:0]               = fifo_out_data;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Answer in the second access cycle, then drop pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= rd_err;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Minimum gap in extended ticks; zero is raised to one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= `CTRL_RESET;
        end else if (apb_wr && paddr == `CTRL_OFS) begin
            gap_r <= (pwdata[7:0] == 8'h00) ? 8'h01
                                            : pwdata[7:0];
        end
    end

    // Overflow is sticky; a new loss beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_r <= 1'b0;
        end else if (mode_r == st_recv && edge_now && pend_valid_r
                     && !fifo_in_ready) begin
            ovf_r <= 1'b1;
        end else if (apb_wr && paddr == `STATUS_OFS
                     && pwdata[`ST_OVF_BIT]) begin
            ovf_r <= 1'b0;
        end
    end
endmodule : rx_clock_enable_data_sync

// file: verif/rx_clock_enable_data_sync_sva.sv
// Purpose: Port checks of the receiver control path.
// Assumes: Band and rate pins hold still while enable_pin is high.
// Notes:   Bound from the testbench top file.
`include "rx_ctl_regs.svh"
module rx_ctl_checker (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire rx_ctl_pkg::addr_t paddr,
    input wire rx_ctl_pkg::word_t pwdata,
    input wire rx_ctl_pkg::word_t prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              enable_pin,
    input wire logic              band_select,
    input wire logic              rate_sel_msb,
    input wire logic              rate_sel_lsb,
    input wire logic              demod_raw,
    input wire logic              data_out
);
    import rx_ctl_pkg::*;

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    int         per;
    int         settle;
    int         since_r;
    logic       seen_r;
    logic [7:0] gap_r;

    // Tick and shortest settle in pclk cycles; one tick of phase slack
    assign per    = (band_select ? 14 : 10)
                  * (rate_sel_msb ? 2 : (rate_sel_lsb ? 4 : 8));
    assign settle = (band_select ? 14 : 10)
                  * ((rate_sel_msb || rate_sel_lsb) ? 512 : 896);

    // Cycles since enable or since the last output edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || !enable_pin) begin
            since_r <= 0;
            seen_r  <= 1'b0;
        end else if ($changed(data_out)) begin
            since_r <= 1;
            seen_r  <= 1'b1;
        end else begin
            since_r <= since_r + 1;
        end
    end

    // Shadow of the gap field; zero reads back as one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= `CTRL_RESET;
        end else if (pready && pwrite && paddr == `CTRL_OFS) begin
            gap_r <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Idle level while asleep and early in settling
    a_sleep_idle: assert property (!enable_pin ##1 !enable_pin |=> data_out)
        else $error("data_out not idle while asleep");
    a_settle_idle: assert property ($rose(enable_pin) |=> data_out [*8])
        else $error("data_out moved early in settling");
    // First edge after enable: late enough and falling
    a_settle_len: assert property (enable_pin && $past(enable_pin)
        && !seen_r && $changed(data_out) |-> since_r >= settle)
        else $error("output started before settling ended");
    a_start_fall: assert property (enable_pin && $past(enable_pin)
        && !seen_r && $changed(data_out) |-> !data_out)
        else $error("output stream did not start on a fall");
    // Edge spacing: whole extended ticks, never under the gap
    a_tick_whole: assert property (enable_pin && $past(enable_pin)
        && seen_r && $changed(data_out) |-> since_r % per == 0)
        else $error("edge spacing not whole extended ticks");
    a_gap_kept: assert property (enable_pin && $past(enable_pin)
        && seen_r && $changed(data_out) |-> since_r >= gap_r * per)
        else $error("edge spacing under the minimum gap");
    a_follow_input: assert property (enable_pin && $past(enable_pin)
        && $changed(data_out) |-> data_out == $past(demod_raw))
        else $error("output edge does not follow the input");
    // Register bus answer timing and error response
    a_ready_slot: assert property ((psel && !penable) ##1
        (psel && penable) |=> pready)
        else $error("pready not one cycle after access");
    a_err_map: assert property (pready |-> pslverr == !(paddr inside
        {`CTRL_OFS, `STATUS_OFS, `EDGE_OFS}))
        else $error("pslverr wrong for address");
    a_err_zero: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : rx_ctl_checker

// file: verif/mcu_model.sv
// Purpose: Controller model driving the enable and rate pins.
// Assumes: The bench requests a state; pins move after pclk edges.
// Notes:   Band and rate pins move only while the receiver sleeps.
module mcu_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       want_on,
    input  wire logic [1:0] want_rate,
    input  wire logic       want_band,
    output logic            enable_pin,
    output logic            band_select,
    output logic            rate_sel_msb,
    output logic            rate_sel_lsb
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Enable held high for as long as reception is wanted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_pin <= 1'b0;
        end else begin
            enable_pin <= want_on;
        end
    end

    // Rates follow the link baud; frozen mid-reception to keep ticks sane
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {band_select, rate_sel_msb, rate_sel_lsb} <= 3'h0;
        end else if (!enable_pin) begin
            band_select <= want_band;
            {rate_sel_msb, rate_sel_lsb} <= want_rate;
        end
    end
endmodule : mcu_model

// file: verif/rx_clock_enable_data_sync_test.sv
// Purpose: Self-checking bench of the receiver control path.
// Assumes: 10 MHz pclk; demod_raw is driven from here.
// Notes:   Demod edges other than one deliberate spike stay far apart, inside every range's limits.
`include "rx_ctl_regs.svh"
module rx_clock_enable_data_sync_test;
    timeunit 1ns;
    timeprecision 1ns;
    import rx_ctl_pkg::*;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic       pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic       pwrite = 1'b0, demod_raw = 1'b1, want_on = 1'b0;
    logic       want_band = 1'b0, pready, pslverr, data_out, rd_err;
    logic       enable_pin, band_select, rate_sel_msb, rate_sel_lsb;
    logic [1:0] want_rate = 2'h0;
    addr_t      paddr = 12'h000;
    word_t      pwdata = 32'h0, prdata, rd;
    int         n_errors = 0, comparisons = 0, i;

    rx_clock_enable_data_sync dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
        .band_select(band_select), .rate_sel_msb(rate_sel_msb),
        .rate_sel_lsb(rate_sel_lsb), .demod_raw(demod_raw),
        .data_out(data_out));
    mcu_model u_mcu (
        .pclk(pclk), .presetn(presetn), .want_on(want_on),
        .want_rate(want_rate), .want_band(want_band),
        .enable_pin(enable_pin), .band_select(band_select),
        .rate_sel_msb(rate_sel_msb), .rate_sel_lsb(rate_sel_lsb));

    // 100 ns period
    always #50 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: saw %h, want %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input addr_t a, input word_t d);
        int c;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (c = 0; c < 20; c++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd      = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (c == 20) begin
            check({31'h0, pready}, 32'h1);
            tally_and_finish();
        end
    endtask : apb

    task automatic st_chk(input int lsb, input word_t m, input word_t exp);
        apb(1'b0, `STATUS_OFS, 32'h0);
        check((rd >> lsb) & m, exp);
    endtask : st_chk

    // Bounded wait for an output level; running out ends the run
    task automatic wait_out(input logic v, input int lim);
        int c;
        for (c = 0; c < lim && data_out !== v; c++) @(posedge pclk);
        check({31'h0, data_out}, {31'h0, v});
        if (data_out !== v) tally_and_finish();
    endtask : wait_out

    task automatic hold_out(input logic v, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            if (data_out !== v) bad = 1'b1;
        end
        check({31'h0, bad}, 32'h0);
    endtask : hold_out

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wait_out(1'b1, 1);
        apb(1'b0, `CTRL_OFS, 32'h0);
        check(rd, {24'h0, `CTRL_RESET});
        st_chk(0, 32'h3, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check({31'h0, rd_err}, 32'h1);
        check(rd, 32'h0);
        // Every rate pin code, ending on 11 (extended tick 20 cycles)
        for (i = 0; i < 4; i++) begin
            want_rate <= i[1:0];
            repeat (3) @(posedge pclk);
            st_chk(2, 32'h3, (i == 3) ? 32'h2 : 32'(i));
        end
        apb(1'b1, `CTRL_OFS, 32'h2);
        apb(1'b0, `CTRL_OFS, 32'h0);
        check(rd, 32'h2);
        // Settling lasts 513 base ticks of 10 cycles
        want_on <= 1'b1;
        repeat (6) @(posedge pclk);
        st_chk(0, 32'h3, 32'h1);
        repeat (5060) @(posedge pclk);
        st_chk(0, 32'h3, 32'h1);
        wait_out(1'b1, 1);
        repeat (100) @(posedge pclk);
        st_chk(0, 32'h3, 32'h2);
        demod_raw <= 1'b0;
        wait_out(1'b0, 60);
        // A spike inside the gap after an edge is dropped
        demod_raw <= 1'b1;
        repeat (10) @(posedge pclk);
        demod_raw <= 1'b0;
        st_chk(0, 32'h3, 32'h3);
        st_chk(4, 32'h1, 32'h0);
        hold_out(1'b0, 60);
        demod_raw <= 1'b1;
        wait_out(1'b1, 80);
        // Overrun the edge queue, then drain it dry
        for (i = 0; i < 11; i++) begin
            repeat (60) @(posedge pclk);
            demod_raw <= i[0];
            wait_out(i[0], 80);
        end
        st_chk(6, 32'h1, 32'h1);
        for (i = 0; i < 20; i++) begin
            apb(1'b0, `EDGE_OFS, 32'h0);
            if (rd[31] !== 1'b1) break;
        end
        check({31'h0, rd[31]}, 32'h0);
        check(32'(i >= `FIFO_DEPTH), 32'h1);
        st_chk(5, 32'h1, 32'h0);
        apb(1'b1, `STATUS_OFS, 32'h40);
        st_chk(6, 32'h1, 32'h0);
        // Sleep: idle at once, input ignored
        want_on <= 1'b0;
        wait_out(1'b1, 4);
        st_chk(0, 32'h3, 32'h0);
        demod_raw <= 1'b0;
        hold_out(1'b1, 60);
        // Band 1, range 1: settle restarts, 513 ticks of 14 cycles
        want_band <= 1'b1;
        want_rate <= 2'h1;
        demod_raw <= 1'b1;
        @(posedge pclk);
        want_on <= 1'b1;
        repeat (20) @(posedge pclk);
        st_chk(0, 32'h3, 32'h1);
        repeat (7090) @(posedge pclk);
        st_chk(0, 32'h3, 32'h1);
        repeat (120) @(posedge pclk);
        st_chk(0, 32'h3, 32'h2);
        for (i = 0; i < 4; i++) begin
            demod_raw <= i[0];
            wait_out(i[0], 150);
            repeat (300) @(posedge pclk);
        end
        tally_and_finish();
    end
endmodule : rx_clock_enable_data_sync_test

bind rx_clock_enable_data_sync rx_ctl_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
    .band_select(band_select), .rate_sel_msb(rate_sel_msb),
    .rate_sel_lsb(rate_sel_lsb), .demod_raw(demod_raw),
    .data_out(data_out));
